//--- lbc_config.v
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ns
// Function
// - Combine field merges acknowledge pins per channel
// - Combine acts only with local bus selected
// - Freed pins carry phase-1 clocks if output
// - Master field drives hold-grant, else input
// - Zero holds data mode machine in reset
// - Zero holds external bus controller in reset
// - Channel A disregard forwards all its interrupts
// - Channel B disregard forwards all its interrupts
// - Disregard zero means local interrupt processing
// - Mode field picks interrupt or DMA mode
// - Shared channel A uses one request, acknowledge
// - Unshared channel A keeps separate DMA signals
// - Direction field sets shared request meaning
// - First input decoding variant and polarity
// - Second input decoding variant and polarity
// - Single input serves both channels
// - Separate inputs: first A, second B
`include "lbc_defs.vh"

module lbc_config (
    input wire clk,
    input wire rstn,
    input wire ce,
    input wire [7:0] addr,
    input wire [31:0] wr_data,
    input wire wr_en,
    input wire rd_en,
    output reg [31:0] rd_data,
    output reg irq,
    input wire first_periph_int_in,
    input wire second_periph_int_in,
    input wire dma_request_chan_a,
    input wire rx_dma_request_chan_a,
    input wire dma_request_chan_b,
    input wire rx_dma_request_chan_b,
    input wire hold_grant_pin_in,
    input wire tx_ack_a,
    input wire rx_ack_a,
    input wire tx_ack_b,
    input wire rx_ack_b,
    input wire arb_grant,
    output reg tx_dma_ack_chan_a,
    output reg rx_dma_ack_chan_a,
    output reg rx_dma_ack_chan_a_oe_n,
    output reg tx_dma_ack_chan_b,
    output reg rx_dma_ack_chan_b,
    output reg rx_dma_ack_chan_b_oe_n,
    output reg hold_grant_pin_out,
    output reg hold_grant_pin_oe_n,
    output reg hold_grant_seen,
    output reg tx_req_a,
    output reg rx_req_a,
    output reg tx_req_b,
    output reg rx_req_b,
    output reg data_mode_fsm_reset_n,
    output reg ext_bus_ctrl_reset_n,
    output reg queue_push,
    output reg queue_chan_b,
    output reg queue_variant_b,
    output reg local_service,
    output reg local_service_chan_b,
    output reg local_service_dma
);

    // ****************************************
    // State machine codes
    // ****************************************
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_CHA = 4'b0010;
    localparam [3:0] ST_CHB = 4'b0100;
    localparam [3:0] ST_WAIT = 4'b1000;
    localparam SYNC_W = 7;

    // ****************************************
    // Registers and synchronisers
    // ****************************************
    reg [31:0] conf_reg;
    reg [31:0] global_reg;
    reg [`LBC_EV_W-1:0] status_reg;
    reg [`LBC_EV_W-1:0] mask_reg;
    reg [SYNC_W-1:0] meta_reg;
    reg [SYNC_W-1:0] sync_reg;
    reg [3:0] state_reg;
    reg [3:0] state_next;
    reg phase_reg;
    reg [`LBC_EV_W-1:0] ev;
    reg [`LBC_EV_W-1:0] status_next;
    reg [31:0] rd_next;
    reg push_next;
    reg push_chan_next;
    reg push_var_next;
    reg svc_next;
    reg svc_chan_next;
    reg svc_dma_next;

    // Field decode
    wire disreg_a = conf_reg[`LBC_B_DISREG_A];
    wire disreg_b = conf_reg[`LBC_B_DISREG_B];
    wire mode_a = conf_reg[`LBC_B_MODE_A];
    wire mode_b = conf_reg[`LBC_B_MODE_B];
    wire sda = conf_reg[`LBC_B_SDA];
    wire dir_tx = conf_reg[`LBC_B_DIR];
    wire dec1 = conf_reg[`LBC_B_DEC1];
    wire dec2 = conf_reg[`LBC_B_DEC2];
    wire sep_int = conf_reg[`LBC_B_SEP_INT];
    wire arb_mst = conf_reg[`LBC_B_ARB_MST];
    wire dms_run = conf_reg[`LBC_B_FSM_RUN];
    wire bus_run = conf_reg[`LBC_B_BUS_RUN];
    wire lb_sel = global_reg[`LBC_B_LBSEL];
    wire clk_dir0 = global_reg[`LBC_B_CLK_DIR0];
    wire clk_dir1 = global_reg[`LBC_B_CLK_DIR1];

    // Synchronised pin levels
    wire int1_s = sync_reg[0];
    wire int2_s = sync_reg[1];
    wire dreq_a_s = sync_reg[2];
    wire rxreq_a_s = sync_reg[3];
    wire dreq_b_s = sync_reg[4];
    wire rxreq_b_s = sync_reg[5];
    wire hold_s = sync_reg[6];

    // Combine takes effect only with the local bus selected
    wire comb_eff = conf_reg[`LBC_B_COMBINE] & lb_sel;
    wire comb_a = comb_eff | sda;
    wire comb_b = comb_eff;

    // Input polarity per decoding variant
    wire int1_act = dec1 ? ~int1_s : int1_s;
    wire int2_act = dec2 ? ~int2_s : int2_s;
    wire pend_a = int1_act;
    wire pend_b = sep_int ? int2_act : int1_act;

    // Register access strobes
    wire wr_conf = wr_en & (addr == `LBC_ADDR_CONF);
    wire wr_glob = wr_en & (addr == `LBC_ADDR_GLOBAL);
    wire wr_stat = wr_en & (addr == `LBC_ADDR_STATUS);
    wire wr_mask = wr_en & (addr == `LBC_ADDR_MASK);

    // ****************************************
    // Data mode state machine, next state
    // ****************************************
    always @* begin
        state_next = state_reg;
        push_next = 1'b0;
        push_chan_next = 1'b0;
        push_var_next = 1'b0;
        svc_next = 1'b0;
        svc_chan_next = 1'b0;
        svc_dma_next = 1'b0;
        ev = {`LBC_EV_W{1'b0}};
        case (state_reg)
            ST_IDLE: begin
                if (pend_a) begin
                    state_next = ST_CHA;
                end else if (pend_b) begin
                    state_next = ST_CHB;
                end
            end
            ST_CHA: begin
                if (disreg_a) begin
                    // Forward every channel A interrupt untouched
                    push_next = 1'b1;
                    push_var_next = dec1;
                    ev[`LBC_EV_PASS_A] = 1'b1;
                end else begin
                    // Handle locally in the channel's mode
                    svc_next = 1'b1;
                    svc_dma_next = mode_a;
                    ev[`LBC_EV_SVC_A] = 1'b1;
                end
                state_next = pend_b ? ST_CHB : ST_WAIT;
            end
            ST_CHB: begin
                if (disreg_b) begin
                    push_next = 1'b1;
                    push_chan_next = 1'b1;
                    push_var_next = sep_int ? dec2 : dec1;
                    ev[`LBC_EV_PASS_B] = 1'b1;
                end else begin
                    svc_next = 1'b1;
                    svc_chan_next = 1'b1;
                    svc_dma_next = mode_b;
                    ev[`LBC_EV_SVC_B] = 1'b1;
                end
                state_next = ST_WAIT;
            end
            ST_WAIT: begin
                // Wait until neither channel has an interrupt pending
                if (!pend_a && !pend_b) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // ****************************************
    // Status next value and read mux
    // ****************************************
    always @* begin
        // Set wins over a write-one clear
        status_next = status_reg;
        if (wr_stat) begin
            status_next = status_reg & ~wr_data[`LBC_EV_W-1:0];
        end
        status_next = status_next | (ev & {`LBC_EV_W{dms_run}});
        case (addr)
            `LBC_ADDR_CONF: rd_next = conf_reg;
            `LBC_ADDR_GLOBAL: rd_next = global_reg;
            `LBC_ADDR_STATUS: rd_next = {{(32-`LBC_EV_W){1'b0}}, status_reg};
            `LBC_ADDR_MASK: rd_next = {{(32-`LBC_EV_W){1'b0}}, mask_reg};
            default: rd_next = 32'h0000_0000;
        endcase
    end

    // ****************************************
    // Register file and interrupt
    // ****************************************
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            conf_reg <= `LBC_RST_CONF;
            global_reg <= `LBC_RST_GLOBAL;
            status_reg <= {`LBC_EV_W{1'b0}};
            mask_reg <= {`LBC_EV_W{1'b0}};
            rd_data <= 32'h0000_0000;
            irq <= 1'b0;
        end else if (ce) begin
            if (wr_conf) begin
                // Reset fields stay as written until software rewrites them
                conf_reg <= wr_data & `LBC_CONF_WMASK;
            end
            if (wr_glob) begin
                global_reg <= {29'h0000_0000, wr_data[2:0]};
            end
            if (wr_mask) begin
                mask_reg <= wr_data[`LBC_EV_W-1:0];
            end
            status_reg <= status_next;
            rd_data <= rd_en ? rd_next : 32'h0000_0000;
            irq <= |(status_next & mask_reg);
        end
    end

    // ****************************************
    // Input synchronisers
    // ****************************************
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_reg <= {SYNC_W{1'b0}};
            sync_reg <= {SYNC_W{1'b0}};
        end else if (ce) begin
            meta_reg <= {hold_grant_pin_in, rx_dma_request_chan_b, dma_request_chan_b,
                         rx_dma_request_chan_a, dma_request_chan_a,
                         second_periph_int_in, first_periph_int_in};
            sync_reg <= meta_reg;
        end
    end

    // ****************************************
    // Data mode state machine registers
    // ****************************************
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ST_IDLE;
            queue_push <= 1'b0;
            queue_chan_b <= 1'b0;
            queue_variant_b <= 1'b0;
            local_service <= 1'b0;
            local_service_chan_b <= 1'b0;
            local_service_dma <= 1'b0;
            data_mode_fsm_reset_n <= 1'b0;
        end else if (ce) begin
            data_mode_fsm_reset_n <= dms_run;
            if (!dms_run) begin
                // Held in its initial state while the field is zero
                state_reg <= ST_IDLE;
                queue_push <= 1'b0;
                queue_chan_b <= 1'b0;
                queue_variant_b <= 1'b0;
                local_service <= 1'b0;
                local_service_chan_b <= 1'b0;
                local_service_dma <= 1'b0;
            end else begin
                state_reg <= state_next;
                queue_push <= push_next;
                queue_chan_b <= push_chan_next;
                queue_variant_b <= push_var_next;
                local_service <= svc_next;
                local_service_chan_b <= svc_chan_next;
                local_service_dma <= svc_dma_next;
            end
        end
    end

    // ****************************************
    // External bus controller: pins and requests
    // ****************************************
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phase_reg <= 1'b0;
            ext_bus_ctrl_reset_n <= 1'b0;
            tx_dma_ack_chan_a <= 1'b0;
            rx_dma_ack_chan_a <= 1'b0;
            rx_dma_ack_chan_a_oe_n <= 1'b1;
            tx_dma_ack_chan_b <= 1'b0;
            rx_dma_ack_chan_b <= 1'b0;
            rx_dma_ack_chan_b_oe_n <= 1'b1;
            hold_grant_pin_out <= 1'b0;
            hold_grant_pin_oe_n <= 1'b1;
            hold_grant_seen <= 1'b0;
            tx_req_a <= 1'b0;
            rx_req_a <= 1'b0;
            tx_req_b <= 1'b0;
            rx_req_b <= 1'b0;
        end else if (ce) begin
            ext_bus_ctrl_reset_n <= bus_run;
            if (!bus_run) begin
                // Held in its initial state while the field is zero
                phase_reg <= 1'b0;
                tx_dma_ack_chan_a <= 1'b0;
                rx_dma_ack_chan_a <= 1'b0;
                rx_dma_ack_chan_a_oe_n <= 1'b1;
                tx_dma_ack_chan_b <= 1'b0;
                rx_dma_ack_chan_b <= 1'b0;
                rx_dma_ack_chan_b_oe_n <= 1'b1;
                hold_grant_pin_out <= 1'b0;
                hold_grant_pin_oe_n <= 1'b1;
                hold_grant_seen <= 1'b0;
                tx_req_a <= 1'b0;
                rx_req_a <= 1'b0;
                tx_req_b <= 1'b0;
                rx_req_b <= 1'b0;
            end else begin
                // Phase-1 clock at half the system clock
                phase_reg <= ~phase_reg;
                // Channel A acknowledge pins
                if (comb_a) begin
                    tx_dma_ack_chan_a <= tx_ack_a | rx_ack_a;
                    rx_dma_ack_chan_a <= comb_eff & ~phase_reg;
                    rx_dma_ack_chan_a_oe_n <= ~(comb_eff & clk_dir0);
                end else begin
                    tx_dma_ack_chan_a <= tx_ack_a;
                    rx_dma_ack_chan_a <= rx_ack_a;
                    rx_dma_ack_chan_a_oe_n <= 1'b0;
                end
                // Channel B acknowledge pins
                if (comb_b) begin
                    tx_dma_ack_chan_b <= tx_ack_b | rx_ack_b;
                    rx_dma_ack_chan_b <= ~phase_reg;
                    rx_dma_ack_chan_b_oe_n <= ~clk_dir1;
                end else begin
                    tx_dma_ack_chan_b <= tx_ack_b;
                    rx_dma_ack_chan_b <= rx_ack_b;
                    rx_dma_ack_chan_b_oe_n <= 1'b0;
                end
                // Arbitration role
                hold_grant_pin_out <= arb_mst & arb_grant;
                hold_grant_pin_oe_n <= ~arb_mst;
                hold_grant_seen <= arb_mst ? arb_grant : hold_s;
                // Requests honoured only in DMA assisted mode
                if (sda) begin
                    tx_req_a <= mode_a & dreq_a_s & dir_tx;
                    rx_req_a <= mode_a & dreq_a_s & ~dir_tx;
                end else begin
                    tx_req_a <= mode_a & dreq_a_s;
                    rx_req_a <= mode_a & rxreq_a_s;
                end
                tx_req_b <= mode_b & dreq_b_s;
                rx_req_b <= mode_b & rxreq_b_s;
            end
        end
    end

endmodule

//--- lbc_defs.vh
`ifndef LBC_DEFS_VH
`define LBC_DEFS_VH

// Register byte addresses
`define LBC_ADDR_CONF 8'h40
`define LBC_ADDR_GLOBAL 8'h80
`define LBC_ADDR_STATUS 8'h84
`define LBC_ADDR_MASK 8'h88

// Reset values and configuration write mask
`define LBC_RST_CONF 32'h0060_0000
`define LBC_RST_GLOBAL 32'h0000_0000
`define LBC_CONF_WMASK 32'hFF7C_1FFF

// Configuration field positions
`define LBC_B_DISREG_A 30
`define LBC_B_DISREG_B 29
`define LBC_B_MODE_A 28
`define LBC_B_MODE_B 27
`define LBC_B_SDA 26
`define LBC_B_DIR 25
`define LBC_B_COMBINE 24
`define LBC_B_BUS_RUN 22
`define LBC_B_FSM_RUN 21
`define LBC_B_DEC1 12
`define LBC_B_DEC2 11
`define LBC_B_SEP_INT 10
`define LBC_B_ARB_MST 4

// Global register fields
`define LBC_B_LBSEL 0
`define LBC_B_CLK_DIR0 1
`define LBC_B_CLK_DIR1 2

// Status and mask bits
`define LBC_EV_PASS_A 0
`define LBC_EV_PASS_B 1
`define LBC_EV_SVC_A 2
`define LBC_EV_SVC_B 3
`define LBC_EV_W 4

`endif

//--- lbc_config_checker.sv
`timescale 1ns/1ns
`include "lbc_defs.vh"
// ************************************************
// Port checker for the configuration block
// ************************************************
module lbc_config_checker (
    input wire clk,
    input wire rstn,
    input wire ce,
    input wire [7:0] addr,
    input wire [31:0] wr_data,
    input wire wr_en,
    input wire rd_en,
    input wire [31:0] rd_data,
    input wire arb_grant,
    input wire hold_grant_pin_out,
    input wire hold_grant_pin_oe_n,
    input wire tx_req_a,
    input wire tx_dma_ack_chan_a,
    input wire queue_push,
    input wire queue_chan_b,
    input wire queue_variant_b,
    input wire local_service,
    input wire local_service_chan_b
);
    reg [31:0] sh_reg;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Shadow copy of the configuration word, as software wrote it
    always @(posedge clk or negedge rstn) begin
        if (!rstn)
            sh_reg <= `LBC_RST_CONF;
        else if (ce && wr_en && addr == `LBC_ADDR_CONF)
            sh_reg <= wr_data & `LBC_CONF_WMASK;
    end
    // Soft reset fields held low for several cycles
    sequence s_fsm_held; !sh_reg[21] [*4]; endsequence
    sequence s_ebc_held; !sh_reg[22] [*4]; endsequence
    property p_rd_conf; ce && rd_en && addr == `LBC_ADDR_CONF |=> rd_data == $past(sh_reg); endproperty
    a_rd_conf: assert property (p_rd_conf) else $error("config read back wrong");
    property p_fsm_held; s_fsm_held |-> !queue_push && !local_service; endproperty
    a_fsm_held: assert property (p_fsm_held) else $error("pulse while machine held");
    property p_ebc_held; s_ebc_held |-> hold_grant_pin_oe_n && !tx_req_a && !tx_dma_ack_chan_a; endproperty
    a_ebc_held: assert property (p_ebc_held) else $error("bus outputs active in reset");
    property p_hg_oe; $past(sh_reg[22]) |-> hold_grant_pin_oe_n == !$past(sh_reg[4]); endproperty
    a_hg_oe: assert property (p_hg_oe) else $error("hold grant enable wrong");
    property p_hg_out; hold_grant_pin_out |-> $past(arb_grant) && $past(sh_reg[4]); endproperty
    a_hg_out: assert property (p_hg_out) else $error("hold grant driven wrongly");
    property p_fwd; queue_push |-> (queue_chan_b ? sh_reg[29] : sh_reg[30]); endproperty
    a_fwd: assert property (p_fwd) else $error("forward without disregard");
    property p_local; local_service |-> !(local_service_chan_b ? sh_reg[29] : sh_reg[30]); endproperty
    a_local: assert property (p_local) else $error("local service with disregard");
    property p_var; queue_push && !queue_chan_b |-> queue_variant_b == sh_reg[12]; endproperty
    a_var: assert property (p_var) else $error("decoding variant wrong");
endmodule

bind lbc_config lbc_config_checker u_chk (.clk, .rstn, .ce, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
    .arb_grant, .hold_grant_pin_out, .hold_grant_pin_oe_n, .tx_req_a, .tx_dma_ack_chan_a, .queue_push,
    .queue_chan_b, .queue_variant_b, .local_service, .local_service_chan_b);

//--- lbc_periph_model.sv
`timescale 1ns/1ns
// ************************************************
// Peripheral controllers on the local bus
// ************************************************
module lbc_periph_model (
    input wire clk,
    input wire shared,
    input wire [1:0] int_cmd,
    input wire [1:0] low_act,
    input wire [3:0] req_cmd,
    output wire first_periph_int_in,
    output wire second_periph_int_in,
    output wire dma_request_chan_a,
    output wire rx_dma_request_chan_a,
    output wire dma_request_chan_b,
    output wire rx_dma_request_chan_b
);
    reg spare_reg = 1'h0;
    // Unused rx line flips every cycle when sharing
    always @(posedge clk) spare_reg <= ~spare_reg;
    // Interrupt pins at the programmed polarity
    assign first_periph_int_in = int_cmd[0] ^ low_act[0];
    assign second_periph_int_in = int_cmd[1] ^ low_act[1];
    // Shared mode carries both directions on one line
    assign dma_request_chan_a = shared ? (req_cmd[0] | req_cmd[1]) : req_cmd[0];
    assign rx_dma_request_chan_a = shared ? spare_reg : req_cmd[1];
    assign dma_request_chan_b = req_cmd[2];
    assign rx_dma_request_chan_b = req_cmd[3];
endmodule

//--- lbc_config_tb.sv
`timescale 1ns/1ns
`include "lbc_defs.vh"
// ************************************************
// Testbench
// ************************************************
module lbc_config_tb;
    logic clk, rstn, ce, wr_en, rd_en, tx_ack_a, rx_ack_a, tx_ack_b, rx_ack_b, arb_grant, hg_ext, shared;
    logic [7:0] addr;
    logic [31:0] wr_data, rd_data;
    logic [1:0] int_cmd, low_act;
    logic [3:0] req_cmd;
    logic irq, tx_dma_ack_chan_a, rx_dma_ack_chan_a, rx_dma_ack_chan_a_oe_n, tx_dma_ack_chan_b, rx_dma_ack_chan_b;
    logic rx_dma_ack_chan_b_oe_n, hold_grant_pin_out, hold_grant_pin_oe_n, hold_grant_seen, hold_grant_pin_in;
    logic tx_req_a, rx_req_a, tx_req_b, rx_req_b, data_mode_fsm_reset_n, ext_bus_ctrl_reset_n, queue_push;
    logic queue_chan_b, queue_variant_b, local_service, local_service_chan_b, local_service_dma;
    logic first_periph_int_in, second_periph_int_in, dma_request_chan_a, rx_dma_request_chan_a;
    logic dma_request_chan_b, rx_dma_request_chan_b;
    int num_errors = 0;
    int cmp_count = 0;

    lbc_config u_dut (.*);
    lbc_periph_model u_peri (.*);
    // Hold-grant wire level from both parties
    assign hold_grant_pin_in = hold_grant_pin_oe_n ? hg_ext : hold_grant_pin_out;
    always #10 clk = ~clk;

    task end_sim;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask
    // Register bus cycles
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'h1;
        @(posedge clk);
        wr_en <= 1'h0;
    endtask
    task rc(input string n, input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'h1;
        @(posedge clk);
        rd_en <= 1'h0;
        #1 chk(n, e, rd_data);
    endtask
    // Reconfigure with both soft resets cleared first
    task cfg(input logic [31:0] v);
        wr(`LBC_ADDR_CONF, v & 32'hFF9F_FFFF);
        low_act <= {v[11], v[12]};
        shared <= v[26];
        repeat (3) @(posedge clk);
        wr(`LBC_ADDR_CONF, v);
        repeat (4) @(posedge clk);
        #1;
    endtask
    // Raise one peripheral interrupt, expect {variant, dma, chan b, push, local}
    task irq_ev(input int k, input logic [4:0] e);
        logic [4:0] p;
        p = 5'h00;
        @(posedge clk);
        int_cmd[k] <= 1'h1;
        for (int i = 0; i < 10 && p == 5'h00; i++) begin
            @(posedge clk);
            #1;
            if (queue_push | local_service)
                p = {queue_push & queue_variant_b, local_service & local_service_dma,
                     queue_push ? queue_chan_b : local_service_chan_b, queue_push, local_service};
        end
        chk("pulse", e, p);
        repeat (6) @(posedge clk);
        int_cmd[k] <= 1'h0;
        repeat (4) @(posedge clk);
    endtask

    task t_regs;
        rc("conf reset", `LBC_ADDR_CONF, `LBC_RST_CONF);
        rc("global reset", `LBC_ADDR_GLOBAL, `LBC_RST_GLOBAL);
        wr(8'h10, 32'hFFFF_FFFF);
        rc("unmapped", 8'h10, 32'h0);
        wr(`LBC_ADDR_CONF, 32'hFFFF_FFFF);
        rc("conf mask", `LBC_ADDR_CONF, `LBC_CONF_WMASK);
        chk("ext reset", 1, ext_bus_ctrl_reset_n);
        cfg(`LBC_RST_CONF);
    endtask
    task t_int;
        wr(`LBC_ADDR_STATUS, 32'h0000_000F);
        cfg(32'h4060_1400);
        irq_ev(0, 5'h12);
        irq_ev(1, 5'h05);
        rc("status", `LBC_ADDR_STATUS, 32'h9);
        chk("irq masked", 0, irq);
        wr(`LBC_ADDR_MASK, 32'h1);
        @(posedge clk);
        #1 chk("irq", 1, irq);
        wr(`LBC_ADDR_STATUS, 32'h1);
        #1 chk("irq clr", 0, irq);
        rc("status clr", `LBC_ADDR_STATUS, 32'h8);
        wr(`LBC_ADDR_STATUS, 32'h8);
        cfg(32'h3060_0000);
        irq_ev(1, 5'h00);
        irq_ev(0, 5'h09);
        rc("status both", `LBC_ADDR_STATUS, 32'h6);
        cfg(32'h0040_0000);
        chk("dms reset", 0, data_mode_fsm_reset_n);
        irq_ev(0, 5'h00);
    endtask
    task t_arb;
        @(posedge clk);
        arb_grant <= 1'h1;
        cfg(32'h0060_0010);
        chk("hg out", 1, hold_grant_pin_out);
        chk("hg oe", 0, hold_grant_pin_oe_n);
        cfg(`LBC_RST_CONF);
        chk("hg oe", 1, hold_grant_pin_oe_n);
        chk("hg seen", 0, hold_grant_seen);
        @(posedge clk);
        hg_ext <= 1'h1;
        arb_grant <= 1'h0;
        repeat (4) @(posedge clk);
        #1 chk("hg seen", 1, hold_grant_seen);
    endtask
    task t_dma;
        logic b;
        cfg(32'h1860_0000);
        @(posedge clk);
        req_cmd <= 4'h9;
        repeat (4) @(posedge clk);
        #1 chk("tx req", 1, tx_req_a);
        chk("rx req", 0, rx_req_a);
        chk("tx req b", 0, tx_req_b);
        chk("rx req b", 1, rx_req_b);
        cfg(`LBC_RST_CONF);
        chk("tx req int", 0, tx_req_a);
        chk("rx req b int", 0, rx_req_b);
        @(posedge clk);
        req_cmd <= 4'h2;
        cfg(32'h1660_0000);
        chk("shared tx", 1, tx_req_a);
        chk("shared rx", 0, rx_req_a);
        cfg(32'h1460_0000);
        chk("shared tx", 0, tx_req_a);
        chk("shared rx", 1, rx_req_a);
        @(posedge clk);
        req_cmd <= 4'h0;
        rx_ack_a <= 1'h1;
        rx_ack_b <= 1'h1;
        repeat (2) @(posedge clk);
        #1 chk("ack a", 1, tx_dma_ack_chan_a);
        chk("ack oe", 1, rx_dma_ack_chan_a_oe_n);
        wr(`LBC_ADDR_GLOBAL, 32'h3);
        cfg(32'h0160_0000);
        chk("comb ack", 1, tx_dma_ack_chan_a);
        chk("comb ack b", 1, tx_dma_ack_chan_b);
        chk("clk oe", 0, rx_dma_ack_chan_a_oe_n);
        chk("pci oe", 1, rx_dma_ack_chan_b_oe_n);
        b = rx_dma_ack_chan_a;
        @(posedge clk);
        #1 chk("phase", !b, rx_dma_ack_chan_a);
        wr(`LBC_ADDR_GLOBAL, 32'h0);
        repeat (2) @(posedge clk);
        #1 chk("sep tx ack", 0, tx_dma_ack_chan_a);
        chk("sep rx ack", 1, rx_dma_ack_chan_a);
        chk("sep oe", 0, rx_dma_ack_chan_a_oe_n);
        chk("sep rx ack b", 1, rx_dma_ack_chan_b);
        chk("sep tx ack b", 0, tx_dma_ack_chan_b);
    endtask

    // Watchdog against a hang
    initial begin
        #100000;
        num_errors++;
        end_sim;
    end
    // Reset, then the scenarios
    initial begin
        {clk, rstn, wr_en, rd_en, tx_ack_a, rx_ack_a, tx_ack_b, rx_ack_b, arb_grant, hg_ext, shared} = 11'h000;
        {addr, wr_data, int_cmd, low_act, req_cmd} = 48'h0;
        ce = 1'h1;
        repeat (8) @(posedge clk);
        rstn <= 1'h1;
        t_regs;
        t_int;
        t_arb;
        t_dma;
        end_sim;
    end
endmodule
